// [core/aswc_core.v]
// serial frame engine: word formatting, frame check words, timeout, result clipping
`include "aswc_map.vh"

module aswc_core
#(
    parameter          RAW_W          = 26,
    parameter          TIMEOUT_CYCLES = `ASWC_TIMEOUT_MCLK,
    parameter          OSR_BASE       = `ASWC_OSR_BASE_MCLK
)
(
    input  wire                  clk,
    input  wire                  rstn,
    input  wire [3:0]            addr,
    input  wire [31:0]           wdata,
    input  wire                  wr,
    input  wire                  rd,
    output reg  [31:0]           rdata,
    input  wire                  cs_n,
    input  wire                  sclk,
    input  wire                  din,
    output reg                   dout,
    output reg                   dout_oe,
    output reg                   data_ready_n,
    input  wire [3*RAW_W-1:0]    ch_raw,
    output reg                   reg_wr_valid,
    output reg  [5:0]            reg_wr_addr,
    output reg  [15:0]           reg_wr_data,
    output reg                   dev_reset_pulse
);

    // configuration and status
    reg  [1:0]  word_length_sel;
    reg         rx_crc_en;
    reg         crc_ansi;
    reg         timeout_en;
    reg  [2:0]  ch_en;
    reg  [2:0]  oversampling_ratio;
    reg         crc_err_reg;
    reg  [2:0]  channel_ready_bits;
    wire [15:0] status_word;

    // pin synchronisers and filtered levels
    reg  [2:0]  cs_sync;
    reg  [2:0]  sclk_sync;
    reg  [2:0]  din_sync;
    reg         cs_lvl;
    reg         sclk_lvl;
    reg         din_lvl;
    wire        cs_chg;
    wire        sclk_chg;
    wire        sclk_rise;
    wire        sclk_fall;

    // frame state
    reg  [4:0]  rx_bit;
    reg  [7:0]  rx_word;
    reg  [30:0] rx_sh;
    reg  [15:0] rx_crc;
    reg  [15:0] cmd_reg;
    reg         crc_seen;
    reg         crc_bad;
    reg  [4:0]  tx_bit;
    reg  [7:0]  tx_word;
    reg  [15:0] tx_crc;
    reg  [15:0] resp_reg;
    reg         resp_status;
    reg  [15:0] tx_resp;
    reg         tx_resp_status;
    reg  [71:0] tx_data;
    reg         frame_act;
    reg  [15:0] to_cnt;
    wire [4:0]  mode_rst_val;
    wire [6:0]  clk_rst_val;

    // results
    reg  [71:0] res_reg;
    reg  [16:0] div_cnt;
    wire        sample_tick;
    wire [71:0] res_clip;

    wire [4:0]  wl_last;
    wire [31:0] rx_full;
    wire [15:0] rx_top;
    wire        cmd_register_write_cmd;
    wire [7:0]  crc_idx;
    wire [15:0] rx_crc_nx;
    wire [15:0] tx_crc_nx;
    wire        tx_bit_val;
    reg  [31:0] tx_fmt;
    reg  [23:0] ch_sel;
    wire        timeout_evt;
    wire        frame_end;
    wire        frame_load;
    wire        cmd_done;
    wire        crc_fail;

    assign status_word = {3'h0, crc_err_reg, 9'h000, channel_ready_bits};
    assign mode_rst_val = `ASWC_MODE_RST;
    assign clk_rst_val  = `ASWC_CLK_RST;

    // three-stage sync; a change counts when stages two and three agree
    assign cs_chg    = (cs_sync[1] == cs_sync[2]) && (cs_sync[2] != cs_lvl);
    assign sclk_chg  = (sclk_sync[1] == sclk_sync[2]) && (sclk_sync[2] != sclk_lvl);
    // cs high masks the clock entirely
    assign sclk_rise = sclk_chg && sclk_sync[2] && !cs_lvl;
    assign sclk_fall = sclk_chg && !sclk_sync[2] && !cs_lvl;

    assign wl_last = (word_length_sel == `ASWC_WL_16) ? 5'd15 :
                     (word_length_sel == `ASWC_WL_24) ? 5'd23 : 5'd31;

    // received word left aligned; meaningful 16 bits on top
    assign rx_full  = {rx_sh, din_lvl} << (5'd31 - wl_last);
    assign rx_top   = rx_full[31:16];
    assign cmd_register_write_cmd = (cmd_reg[15:13] == `ASWC_CMD_REGISTER_WRITE_CMD_TOP);
    assign crc_idx  = cmd_register_write_cmd ? ({1'b0, cmd_reg[6:0]} + 8'd2) : 8'd1;

    aswc_crc_step u_rx_crc
    (
        .crc_in    (rx_crc),
        .bit_in    (din_lvl),
        .poly_ansi (crc_ansi),
        .crc_out   (rx_crc_nx)
    );

    aswc_crc_step u_tx_crc
    (
        .crc_in    (tx_crc),
        .bit_in    (tx_bit_val),
        .poly_ansi (crc_ansi),
        .crc_out   (tx_crc_nx)
    );

    // output word formatting per word slot
    always @*
    begin
        ch_sel = 24'h000000;
        tx_fmt = 32'h00000000;
        case (tx_word)
            8'd1: ch_sel = tx_data[23:0];
            8'd2: ch_sel = tx_data[47:24];
            8'd3: ch_sel = tx_data[71:48];
            default: ch_sel = 24'h000000;
        endcase
        if (tx_word == 8'd0)
        begin
            tx_fmt = {tx_resp, 16'h0000};
        end
        else if (tx_word == `ASWC_OUT_CRC_WORD)
        begin
            tx_fmt = {tx_crc, 16'h0000};
        end
        else if (tx_word < `ASWC_OUT_CRC_WORD)
        begin
            case (word_length_sel)
                `ASWC_WL_16:      tx_fmt = {ch_sel[23:8], 16'h0000};
                `ASWC_WL_24:      tx_fmt = {ch_sel, 8'h00};
                `ASWC_WL_32_PAD:  tx_fmt = {ch_sel, 8'h00};
                `ASWC_WL_32_SEXT: tx_fmt = {{8{ch_sel[23]}}, ch_sel};
                default:          tx_fmt = {ch_sel, 8'h00};
            endcase
        end
    end
    assign tx_bit_val = tx_fmt[5'd31 - tx_bit];

    // timeout runs from the first clock edge of a frame
    assign timeout_evt = timeout_en && frame_act &&
                         (to_cnt == TIMEOUT_CYCLES[15:0] - 16'd1);
    assign frame_end   = (cs_chg && cs_sync[2] && frame_act) || timeout_evt;
    assign frame_load  = (cs_chg && !cs_sync[2]) || timeout_evt;
    assign cmd_done    = (rx_word != 8'd0);
    assign crc_fail    = rx_crc_en && crc_seen && crc_bad;

    // clip signed raw results to 24-bit codes
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_clip
            wire signed [RAW_W-1:0] raw;
            assign raw = ch_raw[gi*RAW_W +: RAW_W];
            assign res_clip[gi*24 +: 24] =
                (raw > $signed(24'sh7fffff)) ? 24'h7fffff :
                (raw < $signed(25'sh1800000)) ? 24'h800000 : raw[23:0];
        end
    endgenerate

    assign sample_tick = (div_cnt == ((OSR_BASE[16:0] << oversampling_ratio) - 17'd1));

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            cs_sync   <= 3'h7;
            sclk_sync <= 3'h0;
            din_sync  <= 3'h0;
            cs_lvl    <= 1'b1;
            sclk_lvl  <= 1'b0;
            din_lvl   <= 1'b0;
        end
        else
        begin
            cs_sync   <= {cs_sync[1:0], cs_n};
            sclk_sync <= {sclk_sync[1:0], sclk};
            din_sync  <= {din_sync[1:0], din};
            if (cs_chg)
                cs_lvl <= cs_sync[2];
            if (sclk_chg)
                sclk_lvl <= sclk_sync[2];
            if (din_sync[1] == din_sync[2])
                din_lvl <= din_sync[2];
        end
    end

    // conversion timing and result capture
    always @(posedge clk)
    begin
        if (!rstn || dev_reset_pulse)
        begin
            div_cnt <= 17'h00000;
            res_reg <= 72'h0;
        end
        else if (sample_tick)
        begin
            div_cnt <= 17'h00000;
            res_reg <= res_clip;
        end
        else
        begin
            div_cnt <= div_cnt + 17'd1;
        end
    end

    // serial frame engine
    always @(posedge clk)
    begin
        if (!rstn || dev_reset_pulse)
        begin
            rx_bit  <= 5'h00;
            rx_word <= 8'h00;
            rx_sh   <= 31'h0;
            rx_crc  <= `ASWC_CRC_SEED;
            cmd_reg <= 16'h0000;
            crc_seen <= 1'b0;
            crc_bad  <= 1'b0;
            tx_bit  <= 5'h00;
            tx_word <= 8'h00;
            tx_crc  <= `ASWC_CRC_SEED;
            tx_resp <= 16'h0000;
            tx_resp_status <= 1'b1;
            tx_data <= 72'h0;
            frame_act <= 1'b0;
            to_cnt  <= 16'h0000;
            dout    <= 1'b0;
            dout_oe <= 1'b0;
            reg_wr_valid <= 1'b0;
            reg_wr_addr  <= 6'h00;
            reg_wr_data  <= 16'h0000;
        end
        else
        begin
            reg_wr_valid <= 1'b0;
            dout_oe <= !cs_lvl;
            if (frame_act)
                to_cnt <= to_cnt + 16'd1;
            if (cs_lvl || frame_load)
            begin
                // frame state returns to its start
                rx_bit  <= 5'h00;
                rx_word <= 8'h00;
                rx_crc  <= `ASWC_CRC_SEED;
                tx_crc  <= `ASWC_CRC_SEED;
                tx_bit  <= 5'h00;
                tx_word <= 8'h00;
                crc_seen <= 1'b0;
                crc_bad  <= 1'b0;
                frame_act <= 1'b0;
                to_cnt  <= 16'h0000;
                cmd_reg <= 16'h0000;
                if (frame_load)
                begin
                    tx_resp <= resp_status ? status_word : resp_reg;
                    tx_resp_status <= resp_status;
                    tx_data <= res_reg;
                end
            end
            else
            begin
                if (sclk_rise)
                begin
                    frame_act <= 1'b1;
                    dout <= tx_bit_val;
                    if (tx_word < `ASWC_OUT_CRC_WORD)
                        tx_crc <= tx_crc_nx;
                    if (tx_bit == wl_last)
                    begin
                        tx_bit <= 5'h00;
                        if (tx_word != 8'hff)
                            tx_word <= tx_word + 8'd1;
                    end
                    else
                        tx_bit <= tx_bit + 5'd1;
                end
                if (sclk_fall)
                begin
                    frame_act <= 1'b1;
                    rx_sh <= {rx_sh[29:0], din_lvl};
                    if (!cmd_done || rx_word < crc_idx)
                        rx_crc <= rx_crc_nx;
                    if (rx_bit == wl_last)
                    begin
                        rx_bit <= 5'h00;
                        if (rx_word != 8'hff)
                            rx_word <= rx_word + 8'd1;
                        if (!cmd_done)
                            cmd_reg <= rx_top;
                        else if (rx_word == crc_idx)
                        begin
                            crc_seen <= 1'b1;
                            crc_bad  <= (rx_top != rx_crc);
                        end
                        else if (cmd_register_write_cmd && rx_word <= {1'b0, cmd_reg[6:0]} + 8'd1)
                        begin
                            // writes go out as they arrive, before any check
                            reg_wr_valid <= 1'b1;
                            reg_wr_addr  <= cmd_reg[12:7] + rx_word[5:0] - 6'd1;
                            reg_wr_data  <= rx_top;
                        end
                    end
                    else
                        rx_bit <= rx_bit + 5'd1;
                end
            end
        end
    end

    // command outcome at frame end; response goes out in the next frame
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            resp_reg <= 16'h0000;
            resp_status <= 1'b1;
            dev_reset_pulse <= 1'b0;
        end
        else
        begin
            dev_reset_pulse <= 1'b0;
            if (frame_end)
            begin
                resp_status <= 1'b1;
                if (cmd_done && crc_fail)
                    resp_status <= 1'b1;
                else if (cmd_done && cmd_reg == `ASWC_CMD_RESET)
                begin
                    resp_status <= 1'b0;
                    if (rx_word >= `ASWC_FRAME_WORDS)
                    begin
                        resp_reg <= `ASWC_RESP_RESET_OK;
                        dev_reset_pulse <= 1'b1;
                    end
                    else
                        resp_reg <= `ASWC_CMD_RESET;
                end
                else if (cmd_done && cmd_register_write_cmd)
                begin
                    resp_status <= 1'b0;
                    resp_reg <= {`ASWC_RESP_REGISTER_WRITE_CMD_TOP, cmd_reg[12:0]};
                end
            end
        end
    end

    // configuration, flags and register port
    always @(posedge clk)
    begin
        if (!rstn || dev_reset_pulse)
        begin
            word_length_sel    <= mode_rst_val[1:0];
            rx_crc_en          <= 1'b0;
            crc_ansi           <= 1'b0;
            timeout_en         <= 1'b0;
            ch_en              <= clk_rst_val[2:0];
            oversampling_ratio <= 3'h0;
            crc_err_reg        <= 1'b0;
            channel_ready_bits <= 3'h0;
            data_ready_n       <= 1'b1;
            rdata              <= 32'h00000000;
        end
        else
        begin
            if (wr && addr == `ASWC_OFF_MODE)
            begin
                word_length_sel <= wdata[`ASWC_MODE_WL_HI:`ASWC_MODE_WL_LO];
                rx_crc_en       <= wdata[`ASWC_MODE_RXCRC];
                crc_ansi        <= wdata[`ASWC_MODE_CRCTYPE];
                timeout_en      <= wdata[`ASWC_MODE_TIMEOUT];
            end
            if (wr && addr == `ASWC_OFF_CLOCK)
            begin
                ch_en              <= wdata[`ASWC_CLK_EN_HI:`ASWC_CLK_EN_LO];
                oversampling_ratio <= wdata[`ASWC_CLK_OSR_HI:`ASWC_CLK_OSR_LO];
            end
            // set wins over clear on the same cycle
            crc_err_reg <= (frame_end && cmd_done && crc_fail) ||
                           (crc_err_reg && !(sclk_rise && tx_word == 8'd0 &&
                            tx_bit == wl_last && tx_resp_status));
            channel_ready_bits <= (sample_tick ? ch_en : 3'h0) |
                (channel_ready_bits & ~((sclk_rise && tx_bit == wl_last &&
                 tx_word >= 8'd1 && tx_word <= 8'd3) ?
                 (3'h1 << (tx_word[1:0] - 2'd1)) : 3'h0));
            data_ready_n <= !(|channel_ready_bits);
            rdata <= 32'h00000000;
            if (rd)
            begin
                case (addr)
                    `ASWC_OFF_MODE:   rdata <= {27'h0, timeout_en, crc_ansi, rx_crc_en,
                                                word_length_sel};
                    `ASWC_OFF_CLOCK:  rdata <= {25'h0, oversampling_ratio, 1'b0, ch_en};
                    `ASWC_OFF_STATUS: rdata <= {16'h0000, status_word};
                    default:          rdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// [core/aswc_crc_step.v]
// one serial step of the 16-bit check word, msb first, no reflection
module aswc_crc_step
(
    input  wire [15:0] crc_in,
    input  wire        bit_in,
    input  wire        poly_ansi,
    output wire [15:0] crc_out
);
`include "aswc_map.vh"

    wire        fb;
    wire [15:0] poly;

    assign fb      = crc_in[15] ^ bit_in;
    assign poly    = poly_ansi ? `ASWC_POLY_ANSI : `ASWC_POLY_CCITT;
    assign crc_out = {crc_in[14:0], 1'b0} ^ (fb ? poly : 16'h0000);

endmodule

// [core/aswc_map.vh]
// offsets, field positions, reset values and timing counts of the serial word block
`ifndef ASWC_MAP_VH
`define ASWC_MAP_VH

`define ASWC_ADDR_W          4
`define ASWC_OFF_MODE        4'h0
`define ASWC_OFF_CLOCK       4'h4
`define ASWC_OFF_STATUS      4'h8

`define ASWC_MODE_WL_LO      0
`define ASWC_MODE_WL_HI      1
`define ASWC_MODE_RXCRC      2
`define ASWC_MODE_CRCTYPE    3
`define ASWC_MODE_TIMEOUT    4
`define ASWC_MODE_RST        5'h01

`define ASWC_CLK_EN_LO       0
`define ASWC_CLK_EN_HI       2
`define ASWC_CLK_OSR_LO      4
`define ASWC_CLK_OSR_HI      6
`define ASWC_CLK_RST         7'h07

`define ASWC_WL_16           2'h0
`define ASWC_WL_24           2'h1
`define ASWC_WL_32_PAD       2'h2
`define ASWC_WL_32_SEXT      2'h3

`define ASWC_ST_CRCERR       12
`define ASWC_CMD_RESET       16'h0011
`define ASWC_RESP_RESET_OK   16'hff23
`define ASWC_CMD_REGISTER_WRITE_CMD_TOP    3'h3
`define ASWC_RESP_REGISTER_WRITE_CMD_TOP   3'h2
`define ASWC_CRC_SEED        16'hffff
`define ASWC_POLY_CCITT      16'h1021
`define ASWC_POLY_ANSI       16'h8005
`define ASWC_FRAME_WORDS     5
`define ASWC_OUT_CRC_WORD    4

`define ASWC_TIMEOUT_MCLK    32768
`define ASWC_OSR_BASE_MCLK   128

`endif

// [verification/aswc_core_chk.sv]
// port-level checks for the serial word block
module aswc_core_chk
(
    input wire        clk,
    input wire        rstn,
    input wire [3:0]  addr,
    input wire        rd,
    input wire [31:0] rdata,
    input wire        cs_n,
    input wire        sclk,
    input wire        dout,
    input wire        dout_oe,
    input wire        data_ready_n,
    input wire        reg_wr_valid,
    input wire        dev_reset_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // pin path is three sync flops, the filtered level register and the output register
    property p_oe_off;
        cs_n [*7] |-> !dout_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output enabled while deselected");

    property p_oe_on;
        !cs_n [*7] |-> dout_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("output not enabled while selected");

    // a falling serial edge must never move the output bit
    property p_dout_hold;
        !cs_n && $fell(sclk) |=> $stable(dout) [*6];
    endproperty
    a_dout_hold: assert property (p_dout_hold) else $error("output moved after falling edge");

    property p_rst_after_cs;
        dev_reset_pulse |-> $past(cs_n, 2);
    endproperty
    a_rst_after_cs: assert property (p_rst_after_cs) else $error("reset inside a frame");

    property p_rst_single;
        dev_reset_pulse |=> !dev_reset_pulse;
    endproperty
    a_rst_single: assert property (p_rst_single) else $error("reset pulse too long");

    property p_wr_in_frame;
        reg_wr_valid |-> dout_oe && !cs_n;
    endproperty
    a_wr_in_frame: assert property (p_wr_in_frame) else $error("register write outside frame");

    property p_rdata_idle;
        !$past(rd) |-> rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

    property p_ready_pin;
        rd && addr == 4'h8 ##1 rdata[2:0] != 3'h0 |-> ##[0:2] !data_ready_n;
    endproperty
    a_ready_pin: assert property (p_ready_pin) else $error("ready bits set, ready pin high");
endmodule

// [verification/aswc_host_model.sv]
// host controller model: frames on chip select, serial clock and serial input
module aswc_host_model
(
    output logic cs_n,
    output logic sclk,
    output logic din,
    input  wire  dout
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] tx [0:7];
    logic [31:0] rx [0:7];
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din  = 1'b1;
    end
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b,
                                             input logic ansi);
        logic [15:0] p;
        p = ansi ? 16'h8005 : 16'h1021;
        return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? p : 16'h0); // msb first, no xor-out
    endfunction
    // wb bits a word, nb bits in all; word ca carries the check word, bad spoils it
    task automatic xfer(input logic [31:0] cmd, input logic [31:0] d1, input int wb,
                        input int nb, input int ca, input logic bad, input logic ansi,
                        input logic hold);
        logic [15:0] crc;
        int          w;
        int          k;
        crc = 16'hffff;
        for (int i = 0; i < 8; i++)
        begin
            rx[i] = 32'h0;
            tx[i] = (i == 0) ? cmd : (i == 1) ? d1 : 32'h0; // trailing zero words
        end
        if (cs_n)
        begin
            cs_n = 1'b0; // held low for the whole frame
            #125;
        end
        for (int i = 0; i < nb; i++)
        begin
            w = i / wb;
            k = wb - 1 - i % wb;
            if (k == wb - 1 && w == ca)
                tx[w] = {16'h0, crc ^ {15'h0, bad}} << (wb - 16);
            if (w < ca)
                crc = crc_step(crc, tx[w][k], ansi);
            sclk = 1'b1;
            din  = tx[w][k];
            #62.5;
            sclk = 1'b0;
            rx[w][k] = dout;
            #62.5;
        end
        if (!hold)
        begin
            #125;
            cs_n = 1'b1;
            din  = ~din; // released line must not keep a stale level
            #250;
        end
    endtask
endmodule

// [verification/aswc_tb_top.sv]
// top-level bench for the serial word block
module aswc_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TMO = 2048;
    logic        clk;
    logic        rstn;
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic [77:0] ch_raw;
    logic [15:0] last_wd;
    logic [5:0]  last_wa;
    wire  [31:0] rdata;
    wire  [5:0]  reg_wr_addr;
    wire  [15:0] reg_wr_data;
    wire         cs_n, sclk, din, dout, dout_oe, data_ready_n, reg_wr_valid, dev_reset_pulse;
    int          num_errors = 0;
    int          check_count = 0;
    int          rst_cnt = 0;
    int          wr_cnt = 0;
    logic [23:0] expd [0:2] = '{24'h7fffff, 24'h800000, 24'hffff00};

    aswc_core #(.TIMEOUT_CYCLES(TMO), .OSR_BASE(16)) u_dut
    (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe(dout_oe), .data_ready_n(data_ready_n), .ch_raw(ch_raw),
        .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .dev_reset_pulse(dev_reset_pulse)
    );
    aswc_host_model u_host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (dev_reset_pulse === 1'b1)
            rst_cnt++;
        if (reg_wr_valid === 1'b1)
        begin
            wr_cnt++;
            last_wd = reg_wr_data;
            last_wa = reg_wr_addr;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic t_regs();
        logic [31:0] d;
        bus_rd(4'h0, d);
        check("mode reset", d, 32'h1);
        bus_rd(4'h4, d);
        check("clock reset", d, 32'h7);
        bus_wr(4'h8, 32'h1007);
        bus_rd(4'h8, d);
        check("status unused bits", d & 32'hfffffff8, 32'h0);
        bus_rd(4'hc, d);
        check("unmapped", d, 32'h0);
        $display("register test done");
    endtask
    task automatic t_format();
        int          wb;
        logic [31:0] e;
        logic [15:0] c;
        for (int s = 0; s < 4; s++)
        begin
            wb = (s < 2) ? 16 + 8 * s : 32;
            bus_wr(4'h0, s | (s % 2) << 3); // polynomial alternates with the width
            u_host.xfer(32'h0, 32'h0, wb, 5 * wb, 8, 1'b0, s % 2, 1'b0);
            check("response pad", u_host.rx[0] << (48 - wb), 32'h0);
            for (int k = 0; k < 3; k++)
            begin
                e = (s == 0) ? expd[k][23:8] : (s == 1) ? expd[k] : (s == 2) ? {expd[k], 8'h0}
                    : {{8{expd[k][23]}}, expd[k]};
                check("result", u_host.rx[k + 1], e);
            end
            c = 16'hffff;
            for (int i = 0; i < 4 * wb; i++)
                c = u_host.crc_step(c, u_host.rx[i / wb][wb - 1 - i % wb], s % 2);
            check("output check", u_host.rx[4], {16'h0, c} << (wb - 16));
        end
        bus_wr(4'h0, 32'h1);
        $display("word format test done");
    endtask
    task automatic t_crc();
        int n;
        int r;
        n = wr_cnt;
        r = rst_cnt;
        bus_wr(4'h0, 32'h5); // 24-bit words, input check on
        u_host.xfer(32'h628000, 32'hbeef00, 24, 120, 2, 1'b1, 1'b0, 1'b0);
        check("write despite bad check", wr_cnt - n, 1);
        check("written data", last_wd, 16'hbeef);
        check("written address", last_wa, 6'h05);
        u_host.xfer(32'h001100, 32'h0, 24, 120, 1, 1'b1, 1'b0, 1'b0);
        check("error flag", u_host.rx[0][20], 1'b1);
        u_host.xfer(32'h0, 32'h0, 24, 120, 1, 1'b0, 1'b0, 1'b0);
        check("reset discarded", rst_cnt - r, 0);
        check("error flag again", u_host.rx[0][20], 1'b1);
        u_host.xfer(32'h0, 32'h0, 24, 120, 1, 1'b0, 1'b0, 1'b0);
        check("error flag cleared", u_host.rx[0][20], 1'b0);
        bus_wr(4'h0, 32'h1);
        $display("input check test done");
    endtask
    task automatic t_reset();
        logic [31:0] d;
        int          r;
        r = rst_cnt;
        bus_wr(4'h4, 32'h0); // channels off so the reset can be seen restoring them
        u_host.xfer(32'h001100, 32'h0, 24, 24, 8, 1'b0, 1'b0, 1'b0);
        check("short reset ignored", rst_cnt - r, 0);
        u_host.xfer(32'h001100, 32'h0, 24, 120, 8, 1'b0, 1'b0, 1'b0);
        check("short reset answer", u_host.rx[0], 32'h001100);
        check("full reset", rst_cnt - r, 1);
        u_host.xfer(32'h0, 32'h0, 24, 120, 8, 1'b0, 1'b0, 1'b0);
        check("reset answer", u_host.rx[0], 32'hff2300);
        bus_rd(4'h4, d);
        check("enables restored", d, 32'h7);
        $display("reset command test done");
    endtask
    task automatic t_timeout();
        int r;
        r = rst_cnt;
        bus_wr(4'h0, 32'h10); // 16-bit words, timeout on
        u_host.xfer(32'h5555, 32'h0, 16, 8, 8, 1'b0, 1'b0, 1'b1);
        repeat (2 * TMO) @(posedge clk);
        u_host.xfer(32'h0011, 32'h0, 16, 80, 8, 1'b0, 1'b0, 1'b0);
        check("reset after timeout", rst_cnt - r, 1);
        $display("timeout test done");
    endtask

    initial
    begin
        rstn   = 1'b0;
        wr     = 1'b0;
        rd     = 1'b0;
        addr   = 4'h0;
        wdata  = 32'h0;
        ch_raw = {26'h3ffff00, 26'h3000000, 26'h0900000}; // two past full scale both ways, one in range
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_format();
        t_crc();
        t_reset();
        t_timeout();
        results();
    end
endmodule

bind aswc_core aswc_core_chk u_chk (.clk(clk), .rstn(rstn), .addr(addr), .rd(rd),
    .rdata(rdata), .cs_n(cs_n), .sclk(sclk), .dout(dout), .dout_oe(dout_oe),
    .data_ready_n(data_ready_n), .reg_wr_valid(reg_wr_valid),
    .dev_reset_pulse(dev_reset_pulse));
